// ===== core/dtc_timer.v
// dual timer/counter with four modes, register port and overflow interrupt
// assumes a register master on mclk; count and gate pins are asynchronous

`include "dtc_map.vh"

module dtc_timer #(
  parameter MC_CLKS = `DTC_MC_CLKS,
  parameter DIV_W = 4
) (
  // clock and reset
  input wire mclk,
  input wire nrst,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // external pins
  input wire count_input_zero,
  input wire count_input_one,
  input wire ext_irq_pin_zero,
  input wire ext_irq_pin_one,
  // interrupt service acknowledges
  input wire svc_ack_zero,
  input wire svc_ack_one,
  // status outputs
  output reg overflow_flag_zero,
  output reg overflow_flag_one,
  output reg baud_tick,
  output reg irq
);

  // ----------------------------------------
  // step of one timer; returns {carry, high, low}
  // ----------------------------------------
  function [16:0] dtc_step;
    input [1:0] m;
    input [7:0] h;
    input [7:0] l;
    reg [13:0] s13;
    reg [16:0] s16;
    reg [8:0] s8;
    begin
      s13 = {1'b0, h, l[4:0]} + 14'h0001;
      s16 = {1'b0, h, l} + 17'h00001;
      s8 = {1'b0, l} + 9'h001;
      case (m)
        `DTC_MODE13: dtc_step = {s13[13], s13[12:5], 3'b000, s13[4:0]};
        `DTC_MODE16: dtc_step = s16;
        `DTC_MODE8R: dtc_step = {s8[8], h, s8[8] ? h : s8[7:0]};
        default: dtc_step = {s8[8], h, s8[7:0]};
      endcase
    end
  endfunction

  // ----------------------------------------
  // exact address match of one strobe
  // ----------------------------------------
  function dtc_hit;
    input strb;
    input [7:0] a;
    input [7:0] ofs;
    begin
      // unmapped addresses hit nothing, so such writes fall away
      dtc_hit = strb & (a == ofs);
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [DIV_W-1:0] div_q;
  reg mc_q;
  reg [3:0] sy1_q;
  reg [3:0] sy2_q;
  reg [1:0] smp_q;
  reg [7:0] mode_q;
  reg [7:0] tl0_q;
  reg [7:0] th0_q;
  reg [7:0] tl1_q;
  reg [7:0] th1_q;
  reg tf0_q;
  reg tf1_q;
  reg tr0_q;
  reg tr1_q;
  reg [3:0] clo_q;
  reg [1:0] ist_q;
  reg [1:0] ien_q;

  // ----------------------------------------
  // next values
  // ----------------------------------------
  reg [7:0] tl0_d;
  reg [7:0] th0_d;
  reg [7:0] tl1_d;
  reg [7:0] th1_d;
  reg tf0_d;
  reg tf1_d;
  reg [1:0] ist_d;
  reg [7:0] rdata_d;
  reg ov0;
  reg ov1;
  reg ovh;
  reg [16:0] st0;
  reg [16:0] st1;
  reg [16:0] sth;

  wire [1:0] m0 = mode_q[`DTC_M0_LSB+1:`DTC_M0_LSB];
  wire [1:0] m1 = mode_q[`DTC_M1_LSB+1:`DTC_M1_LSB];
  wire split = (m0 == `DTC_MODESPLIT);

  // synced pins: [0] count zero, [1] count one, [2] gate zero, [3] gate one
  wire [1:0] edge_s = smp_q & ~sy2_q[1:0];
  wire run0 = tr0_q & (~mode_q[`DTC_GATE0] | sy2_q[2]);
  wire run1 = tr1_q & (~mode_q[`DTC_GATE1] | sy2_q[3]);
  wire inc0 = mc_q & run0 & (mode_q[`DTC_CT0] ? edge_s[0] : 1'b1);
  wire inc1 = mc_q & run1 & (m1 != `DTC_MODESPLIT)
    & (mode_q[`DTC_CT1] ? edge_s[1] : 1'b1);
  // split high byte ignores gate and select: always machine cycles
  wire inch = mc_q & split & tr1_q;

  // in split mode timer one no longer owns its flag
  wire evt1 = split ? ovh : ov1;

  // ----------------------------------------
  // register strobes
  // ----------------------------------------
  wire wr_ctrl = dtc_hit(reg_wr, reg_addr, `DTC_OFS_CTRL);
  wire wr_mode = dtc_hit(reg_wr, reg_addr, `DTC_OFS_MODE);
  wire wr_tl0 = dtc_hit(reg_wr, reg_addr, `DTC_OFS_TL0);
  wire wr_tl1 = dtc_hit(reg_wr, reg_addr, `DTC_OFS_TL1);
  wire wr_th0 = dtc_hit(reg_wr, reg_addr, `DTC_OFS_TH0);
  wire wr_th1 = dtc_hit(reg_wr, reg_addr, `DTC_OFS_TH1);
  wire wr_iclr = dtc_hit(reg_wr, reg_addr, `DTC_OFS_ICLR);
  wire wr_ien = dtc_hit(reg_wr, reg_addr, `DTC_OFS_IEN);

  always @*
  begin
    st0 = dtc_step(m0, th0_q, tl0_q);
    st1 = dtc_step(m1, th1_q, tl1_q);
    sth = dtc_step(`DTC_MODESPLIT, 8'h00, th0_q);
    tl0_d = tl0_q;
    th0_d = th0_q;
    tl1_d = tl1_q;
    th1_d = th1_q;
    ov0 = 1'b0;
    ov1 = 1'b0;
    ovh = 1'b0;
    if (inc0)
    begin
      ov0 = st0[16];
      th0_d = st0[15:8];
      tl0_d = st0[7:0];
    end
    if (inch)
    begin
      ovh = sth[16];
      th0_d = sth[7:0];
    end
    if (inc1)
    begin
      ov1 = st1[16];
      th1_d = st1[15:8];
      tl1_d = st1[7:0];
    end
    // software write overrides a same-cycle step
    if (wr_tl0)
      tl0_d = reg_wdata;
    if (wr_th0)
      th0_d = reg_wdata;
    if (wr_tl1)
      tl1_d = reg_wdata;
    if (wr_th1)
      th1_d = reg_wdata;
    if (m0 == `DTC_MODE13)
      tl0_d[7:5] = 3'b000;
    if (m1 == `DTC_MODE13)
      tl1_d[7:5] = 3'b000;
  end

  // ----------------------------------------
  // overflow flags
  // ----------------------------------------
  always @*
  begin
    // hardware set wins over software or service clear
    tf0_d = tf0_q;
    tf1_d = tf1_q;
    if (wr_ctrl)
    begin
      tf0_d = reg_wdata[`DTC_OVF0];
      tf1_d = reg_wdata[`DTC_OVF1];
    end
    if (svc_ack_zero)
      tf0_d = 1'b0;
    if (svc_ack_one)
      tf1_d = 1'b0;
    if (ov0)
      tf0_d = 1'b1;
    if (evt1)
      tf1_d = 1'b1;
  end

  // ----------------------------------------
  // interrupt status
  // ----------------------------------------
  always @*
  begin
    // a same-cycle event beats the clear so no overflow is lost
    ist_d = ist_q;
    if (wr_iclr)
      ist_d = ist_q & ~reg_wdata[1:0];
    ist_d = ist_d | {evt1, ov0};
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always @*
  begin
    case (reg_addr)
      `DTC_OFS_CTRL: rdata_d = {tf1_q, tr1_q, tf0_q, tr0_q, clo_q};
      `DTC_OFS_MODE: rdata_d = mode_q;
      `DTC_OFS_TL0: rdata_d = tl0_q;
      `DTC_OFS_TL1: rdata_d = tl1_q;
      `DTC_OFS_TH0: rdata_d = th0_q;
      `DTC_OFS_TH1: rdata_d = th1_q;
      `DTC_OFS_IST: rdata_d = {6'h00, ist_q};
      `DTC_OFS_IEN: rdata_d = {6'h00, ien_q};
      default: rdata_d = 8'h00;
    endcase
    if (!reg_rd)
      rdata_d = 8'h00;
  end

  // ----------------------------------------
  // machine cycle divider and pin sampling
  // ----------------------------------------
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_q <= {DIV_W{1'b0}};
      mc_q <= 1'b0;
    end
    else
    begin
      mc_q <= (div_q == MC_CLKS - 1);
      if (div_q == MC_CLKS - 1)
        div_q <= {DIV_W{1'b0}};
      else
        div_q <= div_q + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  // pins idle high; reset value of the sample is low so no false edge follows reset
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      sy1_q <= 4'h0;
      sy2_q <= 4'h0;
      smp_q <= 2'b00;
    end
    else
    begin
      sy1_q <= {ext_irq_pin_one, ext_irq_pin_zero, count_input_one, count_input_zero};
      sy2_q <= sy1_q;
      // one sample per machine cycle, so edges faster than that are missed
      if (mc_q)
        smp_q <= sy2_q[1:0];
    end
  end

  // ----------------------------------------
  // control and mode
  // ----------------------------------------
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      mode_q <= `DTC_RST_BYTE;
      tr0_q <= 1'b0;
      tr1_q <= 1'b0;
      clo_q <= 4'h0;
    end
    else
    begin
      if (wr_mode)
        mode_q <= reg_wdata;
      if (wr_ctrl)
      begin
        // run bits only gate counting; counts stay as they are
        tr0_q <= reg_wdata[`DTC_RUN0];
        tr1_q <= reg_wdata[`DTC_RUN1];
        clo_q <= reg_wdata[3:0];
      end
    end
  end

  // ----------------------------------------
  // counts, flags and their outputs
  // ----------------------------------------
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      tl0_q <= `DTC_RST_BYTE;
      th0_q <= `DTC_RST_BYTE;
      tl1_q <= `DTC_RST_BYTE;
      th1_q <= `DTC_RST_BYTE;
      tf0_q <= 1'b0;
      tf1_q <= 1'b0;
      overflow_flag_zero <= 1'b0;
      overflow_flag_one <= 1'b0;
      baud_tick <= 1'b0;
    end
    else
    begin
      tl0_q <= tl0_d;
      th0_q <= th0_d;
      tl1_q <= tl1_d;
      th1_q <= th1_d;
      tf0_q <= tf0_d;
      tf1_q <= tf1_d;
      // output copies load from the next value so they match the flag bits
      overflow_flag_zero <= tf0_d;
      overflow_flag_one <= tf1_d;
      // tick follows timer one even when split mode takes its flag
      baud_tick <= ov1;
    end
  end

  // ----------------------------------------
  // interrupt and read port
  // ----------------------------------------
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      ist_q <= 2'b00;
      ien_q <= 2'b00;
      irq <= 1'b0;
      reg_rdata <= 8'h00;
    end
    else
    begin
      if (wr_ien)
        ien_q <= reg_wdata[1:0];
      ist_q <= ist_d;
      // enable write acts at once so masking needs no extra cycle
      irq <= |(ist_d & (wr_ien ? reg_wdata[1:0] : ien_q));
      reg_rdata <= rdata_d;
    end
  end

endmodule // dtc_timer

// ===== pkg/dtc_map.vh
// register map, field positions, reset values and timing counts of the dual timer
// assumes inclusion by bare name from the core file
`ifndef DTC_MAP_VH
`define DTC_MAP_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define DTC_OFS_CTRL 8'h88
`define DTC_OFS_MODE 8'h89
`define DTC_OFS_TL0 8'h8a
`define DTC_OFS_TL1 8'h8b
`define DTC_OFS_TH0 8'h8c
`define DTC_OFS_TH1 8'h8d
`define DTC_OFS_IST 8'h90
`define DTC_OFS_ICLR 8'h91
`define DTC_OFS_IEN 8'h92

// ----------------------------------------
// timer_control_flags fields
// ----------------------------------------
`define DTC_OVF1 7
`define DTC_RUN1 6
`define DTC_OVF0 5
`define DTC_RUN0 4

// ----------------------------------------
// timer_mode_config fields
// ----------------------------------------
`define DTC_M0_LSB 0
`define DTC_CT0 2
`define DTC_GATE0 3
`define DTC_M1_LSB 4
`define DTC_CT1 6
`define DTC_GATE1 7

// ----------------------------------------
// modes
// ----------------------------------------
`define DTC_MODE13 2'd0
`define DTC_MODE16 2'd1
`define DTC_MODE8R 2'd2
`define DTC_MODESPLIT 2'd3

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define DTC_RST_BYTE 8'h00
`define DTC_MC_CLKS 12

`endif

// ===== tb/dtc_pin_model.sv
// count and gate pins outside the timer
// assumes mclk is the timer clock; pins idle high as with pull-ups
module dtc_pin_model (
  input wire mclk,
  output logic cnt_zero,
  output logic cnt_one,
  output logic gate_zero,
  output logic gate_one
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    cnt_zero = 1'b1;
    cnt_one = 1'b1;
    gate_zero = 1'b1;
    gate_one = 1'b1;
  end
  // levels held far past one machine cycle plus sync, else edges go unseen
  task automatic pulses(input int n);
    repeat (n)
    begin
      repeat (8) @(posedge mclk);
      cnt_zero <= 1'b0;
      repeat (8) @(posedge mclk);
      cnt_zero <= 1'b1;
    end
  endtask
  task automatic gate(input logic v);
    @(posedge mclk);
    gate_zero <= v;
  endtask
  task automatic pulses_one(input int n);
    repeat (n)
    begin
      repeat (8) @(posedge mclk);
      cnt_one <= 1'b0;
      repeat (8) @(posedge mclk);
      cnt_one <= 1'b1;
    end
  endtask
  task automatic gate_one_set(input logic v);
    @(posedge mclk);
    gate_one <= v;
  endtask
endmodule // dtc_pin_model

// ===== tb/dtc_timer_sva.sv
// port-level assertions for the dual timer
// assumes it is bound onto every dtc_timer instance
module dtc_timer_sva (
  // clock and reset
  input wire mclk,
  input wire nrst,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // service and status
  input wire svc_ack_zero,
  input wire svc_ack_one,
  input wire overflow_flag_zero,
  input wire overflow_flag_one,
  input wire baud_tick,
  input wire irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence ctrl_rd;
    reg_rd && reg_addr == 8'h88;
  endsequence
  sequence ctrl_set1;
    reg_wr && reg_addr == 8'h88 && reg_wdata[7];
  endsequence
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data outside read slot");
  ctrl_read_a: assert property (ctrl_rd |=> reg_rdata[7] == $past(overflow_flag_one) &&
    reg_rdata[5] == $past(overflow_flag_zero)) else $error("flag copy differs from control byte");
  unmapped_rd_a: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00) else $error("unmapped read");
  flag0_hold_a: assert property (overflow_flag_zero && !svc_ack_zero && !(reg_wr && reg_addr == 8'h88)
    |=> overflow_flag_zero) else $error("flag zero dropped");
  flag1_hold_a: assert property (overflow_flag_one && !svc_ack_one && !(reg_wr && reg_addr == 8'h88)
    |=> overflow_flag_one) else $error("flag one dropped");
  flag_write_a: assert property (ctrl_set1 |=> overflow_flag_one) else $error("flag one not written");
  baud_pulse_a: assert property (baud_tick |=> !baud_tick) else $error("tick longer than a cycle");
  irq_mask_a: assert property (reg_wr && reg_addr == 8'h92 && reg_wdata[1:0] == 2'b00 |-> ##2 !irq)
    else $error("irq while masked");
endmodule // dtc_timer_sva

bind dtc_timer dtc_timer_sva u_sva (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .svc_ack_zero(svc_ack_zero),
  .svc_ack_one(svc_ack_one), .overflow_flag_zero(overflow_flag_zero), .overflow_flag_one(overflow_flag_one),
  .baud_tick(baud_tick), .irq(irq));

// ===== tb/tb_top.sv
// self-checking bench for the dual timer
// assumes dtc_map.vh on the include path; short machine cycle for speed
`include "dtc_map.vh"
`define CHK(nm, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("[ERR] %s exp %h got %h", nm, exp, got); \
    end \
  end

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic svc0 = 1'b0;
  logic svc1 = 1'b0;
  logic [7:0] rd_q;
  logic [7:0] v;
  wire [7:0] reg_rdata;
  wire cnt0, cnt1, gt0, gt1, ovf0, ovf1, baud, irq;
  wire [2:0] ev = {baud, ovf1, ovf0};
  int miscompares = 0;
  int n_checks = 0;
  always #5 mclk = ~mclk;
  dtc_pin_model i_pins (.mclk(mclk), .cnt_zero(cnt0), .cnt_one(cnt1), .gate_zero(gt0), .gate_one(gt1));
  dtc_timer #(.MC_CLKS(2)) i_dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_input_zero(cnt0),
    .count_input_one(cnt1), .ext_irq_pin_zero(gt0), .ext_irq_pin_one(gt1), .svc_ack_zero(svc0),
    .svc_ack_one(svc1), .overflow_flag_zero(ovf0), .overflow_flag_one(ovf1), .baud_tick(baud), .irq(irq));
  // ----------------------------------------
  // bus and wait helpers
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    rd_q = reg_rdata;
  endtask
  task automatic wait_sig(input int k);
    for (int i = 0; i < 400 && ev[k] !== 1'b1; i++)
      @(negedge mclk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    for (int a = 8'h88; a <= 8'h8d; a++)
    begin
      rd(a[7:0]);
      `CHK("reset value", 8'h00, rd_q)
    end
    rd(8'h00);
    `CHK("unmapped read", 8'h00, rd_q)
  endtask
  task automatic t_mode0;
    wr(`DTC_OFS_MODE, 8'h00);
    wr(`DTC_OFS_TL0, 8'hfe);
    rd(`DTC_OFS_TL0);
    `CHK("mode0 low byte", 8'h1e, rd_q)
    wr(`DTC_OFS_TH0, 8'hff);
    wr(`DTC_OFS_IEN, 8'h01);
    wr(`DTC_OFS_CTRL, 8'h10);
    wait_sig(0);
    `CHK("wrap flag", 1'b1, ovf0)
    rd(`DTC_OFS_TH0);
    `CHK("thirteen bit wrap", 8'h00, rd_q)
    `CHK("irq raised", 1'b1, irq)
    wr(`DTC_OFS_CTRL, 8'h00);
    `CHK("soft clear", 1'b0, ovf0)
    wr(`DTC_OFS_ICLR, 8'h01);
    @(negedge mclk);
    `CHK("irq cleared", 1'b0, irq)
    wr(`DTC_OFS_IEN, 8'h00);
  endtask
  task automatic t_mode2;
    wr(`DTC_OFS_MODE, 8'h20);
    wr(`DTC_OFS_TH1, 8'hfc);
    wr(`DTC_OFS_TL1, 8'hfe);
    wr(`DTC_OFS_CTRL, 8'h40);
    wait_sig(2);
    `CHK("baud tick", 1'b1, baud)
    `CHK("flag one", 1'b1, ovf1)
    rd(`DTC_OFS_TH1);
    `CHK("reload kept", 8'hfc, rd_q)
    rd(`DTC_OFS_TL1);
    `CHK("reloaded low", 1'b1, rd_q >= 8'hfc)
    wr(`DTC_OFS_CTRL, 8'h80);
    @(posedge mclk);
    svc1 <= 1'b1;
    @(posedge mclk);
    svc1 <= 1'b0;
    @(negedge mclk);
    `CHK("serviced", 1'b0, ovf1)
  endtask
  task automatic t_gate;
    i_pins.gate(1'b0);
    wr(`DTC_OFS_MODE, 8'h09);
    wr(`DTC_OFS_TL0, 8'h00);
    wr(`DTC_OFS_CTRL, 8'h10);
    repeat (20) @(negedge mclk);
    rd(`DTC_OFS_TL0);
    `CHK("gate low", 8'h00, rd_q)
    i_pins.gate(1'b1);
    repeat (20) @(negedge mclk);
    wr(`DTC_OFS_CTRL, 8'h00);
    rd(`DTC_OFS_TL0);
    v = rd_q;
    `CHK("gate high", 1'b1, v != 8'h00)
    repeat (20) @(negedge mclk);
    rd(`DTC_OFS_TL0);
    `CHK("stopped", v, rd_q)
  endtask
  task automatic t_counter;
    wr(`DTC_OFS_MODE, 8'h05);
    wr(`DTC_OFS_TL0, 8'h00);
    wr(`DTC_OFS_CTRL, 8'h10);
    i_pins.pulses(3);
    repeat (10) @(negedge mclk);
    wr(`DTC_OFS_CTRL, 8'h00);
    rd(`DTC_OFS_TL0);
    `CHK("edges counted", 8'h03, rd_q)
  endtask
  task automatic t_split;
    wr(`DTC_OFS_MODE, 8'h33);
    wr(`DTC_OFS_TL1, 8'h55);
    wr(`DTC_OFS_TH0, 8'hfe);
    wr(`DTC_OFS_CTRL, 8'h40);
    wait_sig(1);
    `CHK("high byte flag", 1'b1, ovf1)
    rd(`DTC_OFS_TL1);
    `CHK("timer one held", 8'h55, rd_q)
  endtask
  task automatic t_side;
    wr(`DTC_OFS_MODE, 8'hd0);
    wr(`DTC_OFS_TL1, 8'h00);
    wr(`DTC_OFS_TH1, 8'h00);
    wr(`DTC_OFS_CTRL, 8'h40);
    i_pins.pulses_one(2);
    i_pins.gate_one_set(1'b0);
    i_pins.pulses_one(1);
    repeat (10) @(negedge mclk);
    rd(`DTC_OFS_TL1);
    `CHK("gated edges one", 8'h02, rd_q)
    wr(`DTC_OFS_CTRL, 8'h00);
    wr(`DTC_OFS_ICLR, 8'h03);
    wr(`DTC_OFS_MODE, 8'h02);
    wr(`DTC_OFS_TH0, 8'h80);
    wr(`DTC_OFS_TL0, 8'hfe);
    wr(`DTC_OFS_CTRL, 8'h10);
    wait_sig(0);
    rd(`DTC_OFS_IST);
    `CHK("status zero", 8'h01, rd_q)
    @(posedge mclk);
    svc0 <= 1'b1;
    @(posedge mclk);
    svc0 <= 1'b0;
    @(negedge mclk);
    `CHK("serviced zero", 1'b0, ovf0)
    wr(`DTC_OFS_CTRL, 8'h00);
  endtask
  task automatic give_verdict;
    if (miscompares == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    t_reset;
    t_mode0;
    t_mode2;
    t_gate;
    t_counter;
    t_split;
    t_side;
    give_verdict;
  end
  // well under a fiftieth of this span is needed
  initial
  begin
    #200000;
    miscompares++;
    give_verdict;
  end
endmodule // tb_top
